// ---- stimer_pkg.sv ----
// Contract
// - compare value is one 64-bit register, full precision in both widths.
// - in 32-bit mode low CSR reaches bits 31:0, high CSR bits 63:32.
// - CSR 0x14D decodes as compare (low half), 0x15D as high half.
// - pending is set while time >= compare, both taken as unsigned.
// - a change of the comparison reaches pending after a bounded lag.
// - the interrupt stays posted until compare is above time.
// - interrupt taken only through normal enable and delegation gating.
// - without compare facility, machine pending bit is software writable.
// - with compare facility, machine pending bit is read-only compare signal.
// - supervisor pending bit is read-only, environment or compare driven.
// - compare write at or below time sets pending, above time clears it.
// - supervisor timer enable bits exist in machine and supervisor enables.
// - time access enable clear traps compare access below machine mode.
// - time access enable set permits supervisor access; guest needs hyp enable.
// - environment bit 63 enables facility; clear traps and restores legacy.
package stimer_pkg;
  localparam logic [11:0] CSR_CMP = 12'h14D;
  localparam logic [11:0] CSR_CMP_HI = 12'h15D;
  localparam int XLEN_64 = 64;
  localparam int FACILITY_BIT = 63;
  localparam logic [63:0] CMP_RESET = 64'hFFFFFFFFFFFFFFFF;
  localparam int CMP_LAG = 2;
  typedef enum logic [1:0] {MODE_U, MODE_S, MODE_RSVD, MODE_M} priv_t;
endpackage

// ---- stimer_cmp.sv ----
`timescale 1ns/1ps
// registered unsigned comparator; one stage of lag keeps the 64-bit compare off the csr path
module stimer_cmp (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // operands
  input wire logic [63:0] time_i,
  input wire logic [63:0] cmp_i,
  // result
  output logic ge_o
);
  logic ge_reg;
  logic ge_next;

  always_comb begin
    ge_next = (time_i >= cmp_i);
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ge_reg <= 1'b0;
    end else begin
      ge_reg <= ge_next;
    end
  end

  assign ge_o = ge_reg;
endmodule

// ---- supervisor_timer_compare.sv ----
`timescale 1ns/1ps
module supervisor_timer_compare
  import stimer_pkg::*;
#(
  parameter int XLEN = 64,
  parameter bit IMPLEMENTED = 1'b1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // platform time
  input wire logic [63:0] time_i,
  // csr access from the hart
  input wire logic csr_en_i,
  input wire logic csr_we_i,
  input wire logic [11:0] csr_addr_i,
  input wire logic [63:0] csr_wdata_i,
  input wire stimer_pkg::priv_t priv_i,
  input wire logic virt_i,
  // gating controls from other csrs
  input wire logic [63:0] menv_cfg_i,
  input wire logic time_access_enable_i,
  input wire logic hyp_time_access_enable_i,
  input wire logic henv_facility_enable_i,
  // legacy pending source
  input wire logic mip_supervisor_timer_pending_we_i,
  input wire logic mip_supervisor_timer_pending_wdata_i,
  input wire logic env_supervisor_timer_pending_i,
  // interrupt enables and delegation
  input wire logic mie_supervisor_timer_enable_we_i,
  input wire logic sie_supervisor_timer_enable_we_i,
  input wire logic supervisor_timer_enable_wdata_i,
  input wire logic sti_delegated_i,
  input wire logic mstatus_mie_i,
  input wire logic mstatus_sie_i,
  // results
  output logic [63:0] csr_rdata_o,
  output logic csr_hit_o,
  output logic illegal_o,
  output logic virt_trap_o,
  output logic supervisor_timer_pending_o,
  output logic supervisor_timer_enable_o,
  output logic irq_m_o,
  output logic irq_s_o
);
  import stimer_pkg::*;

  logic [63:0] cmp_reg, cmp_next;
  logic supervisor_timer_pending_sw_reg, supervisor_timer_pending_sw_next;
  logic supervisor_timer_enable_reg, supervisor_timer_enable_next;
  logic pend_reg, pend_next;
  logic [63:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  logic ill_reg, ill_next;
  logic vt_reg, vt_next;
  logic irqm_reg, irqm_next;
  logic irqs_reg, irqs_next;
  logic ge;
  logic facility;
  logic is_lo, is_hi, sel, ok;

  stimer_cmp u_cmp (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .time_i(time_i),
    .cmp_i(cmp_reg),
    .ge_o(ge)
  );

  // decode and access gating
  always_comb begin
    facility = IMPLEMENTED && menv_cfg_i[FACILITY_BIT];
    // csr number decode, high half only in 32-bit mode
    is_lo = (csr_addr_i == CSR_CMP);
    is_hi = (csr_addr_i == CSR_CMP_HI) && (XLEN != XLEN_64);
    sel = csr_en_i && IMPLEMENTED && (is_lo || is_hi);
    ill_next = 1'b0;
    vt_next = 1'b0;
    // time access enable clear traps below machine mode
    if (sel && priv_i != MODE_M && (!time_access_enable_i || !facility)) begin
      ill_next = 1'b1;
    // only supervisor level may reach it, so plain user mode traps
    end else if (sel && priv_i == MODE_U && !virt_i) begin
      ill_next = 1'b1;
    // guest access needs hypervisor enables; guest user mode never gets through
    end else if (sel && priv_i != MODE_M && virt_i &&
                 (!hyp_time_access_enable_i || !henv_facility_enable_i ||
                  priv_i == MODE_U)) begin
      vt_next = 1'b1;
    end
    ok = sel && !ill_next && !vt_next;
  end

  // compare register and legacy pending state
  always_comb begin
    cmp_next = cmp_reg;
    if (ok && csr_we_i) begin
      // full 64 bits or one half
      if (XLEN == XLEN_64) begin
        cmp_next = csr_wdata_i;
      end else if (is_lo) begin
        cmp_next[31:0] = csr_wdata_i[31:0];
      end else begin
        cmp_next[63:32] = csr_wdata_i[31:0];
      end
    end
    supervisor_timer_pending_sw_next = supervisor_timer_pending_sw_reg;
    // writable machine pending only when facility absent
    if (mip_supervisor_timer_pending_we_i && !facility) begin
      supervisor_timer_pending_sw_next = mip_supervisor_timer_pending_wdata_i;
    end
    // enable bit shared by machine and supervisor views
    supervisor_timer_enable_next = supervisor_timer_enable_reg;
    if (mie_supervisor_timer_enable_we_i || sie_supervisor_timer_enable_we_i) begin
      supervisor_timer_enable_next = supervisor_timer_enable_wdata_i;
    end
  end

  // pending, read data and interrupt outputs
  always_comb begin
    // lag is CMP_LAG cycles after a write or time change
    pend_next = facility ? ge : (supervisor_timer_pending_sw_reg | env_supervisor_timer_pending_i);
    hit_next = ok;
    rdata_next = 64'h0000000000000000;
    if (ok) begin
      if (XLEN == XLEN_64) begin
        rdata_next = cmp_reg;
      end else if (is_lo) begin
        rdata_next = {32'h00000000, cmp_reg[31:0]};
      end else begin
        rdata_next = {32'h00000000, cmp_reg[63:32]};
      end
    end
    irqm_next = pend_reg && supervisor_timer_enable_reg && !sti_delegated_i &&
                ((priv_i != MODE_M) || mstatus_mie_i);
    irqs_next = pend_reg && supervisor_timer_enable_reg && sti_delegated_i &&
                ((priv_i == MODE_U) || (priv_i == MODE_S && mstatus_sie_i));
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cmp_reg <= CMP_RESET;
      supervisor_timer_pending_sw_reg <= 1'b0;
      supervisor_timer_enable_reg <= 1'b0;
      pend_reg <= 1'b0;
      rdata_reg <= 64'h0000000000000000;
      hit_reg <= 1'b0;
      ill_reg <= 1'b0;
      vt_reg <= 1'b0;
      irqm_reg <= 1'b0;
      irqs_reg <= 1'b0;
    end else begin
      cmp_reg <= cmp_next;
      supervisor_timer_pending_sw_reg <= supervisor_timer_pending_sw_next;
      supervisor_timer_enable_reg <= supervisor_timer_enable_next;
      pend_reg <= pend_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
      ill_reg <= ill_next;
      vt_reg <= vt_next;
      irqm_reg <= irqm_next;
      irqs_reg <= irqs_next;
    end
  end

  assign csr_rdata_o = rdata_reg;
  assign csr_hit_o = hit_reg;
  assign illegal_o = ill_reg;
  assign virt_trap_o = vt_reg;
  assign supervisor_timer_pending_o = pend_reg;
  assign supervisor_timer_enable_o = supervisor_timer_enable_reg;
  assign irq_m_o = irqm_reg;
  assign irq_s_o = irqs_reg;

  // pending follows compare two cycles later when facility stays on
  a_pend_follows: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    facility && $past(facility) && $past(facility, 2) |->
      pend_reg == ($past(time_i, 2) >= $past(cmp_reg, 2)))
    else $error("pending does not follow compare");

  a_write_full: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ok && csr_we_i && XLEN == XLEN_64 |=> cmp_reg == $past(csr_wdata_i))
    else $error("compare write lost");

  a_trap_tm: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    sel && priv_i != MODE_M && !time_access_enable_i |=> ill_reg && !hit_reg)
    else $error("missing illegal trap");

  a_trap_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ill_next |=> cmp_reg == $past(cmp_reg))
    else $error("trapped access changed compare");

  a_legacy_pend: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !facility && mip_supervisor_timer_pending_we_i ##1 !facility |=>
      pend_reg == ($past(mip_supervisor_timer_pending_wdata_i, 2) | $past(env_supervisor_timer_pending_i)))
    else $error("legacy pending not writable");

  a_ro_pend: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    facility && mip_supervisor_timer_pending_we_i |=> supervisor_timer_pending_sw_reg == $past(supervisor_timer_pending_sw_reg))
    else $error("pending written while read-only");

  a_virt_trap: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    sel && priv_i == MODE_S && virt_i && time_access_enable_i && facility &&
    !hyp_time_access_enable_i |=> vt_reg && !ill_reg)
    else $error("missing virtual trap");

  a_user_trap: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    sel && priv_i == MODE_U |=> !hit_reg && (ill_reg || vt_reg))
    else $error("user mode access not refused");

  a_irq_gate: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    irq_m_o || irq_s_o |-> $past(pend_reg) && $past(supervisor_timer_enable_reg))
    else $error("interrupt without pending and enable");

  a_enable_write: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    mie_supervisor_timer_enable_we_i |=> supervisor_timer_enable_reg == $past(supervisor_timer_enable_wdata_i))
    else $error("enable bit not written");
endmodule

// ---- time_source.sv ----
`timescale 1ns/1ps
// platform time counter; free-running, so the compare result drifts on its own
module time_source (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // preload from the bench
  input wire logic load_i,
  input wire logic [63:0] load_val_i,
  // current time
  output logic [63:0] time_o
);
  logic [63:0] time_reg;
  always_ff @(posedge ref_clk_i) begin
    time_reg <= srst_i ? 64'h0 : (load_i ? load_val_i : time_reg + 64'h1);
  end
  assign time_o = time_reg;
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import stimer_pkg::*;
  logic clk;
  logic srst = 1'b1;
  logic en = 1'b0;
  logic we = 1'b0;
  logic virt = 1'b0;
  logic tae = 1'b1;
  logic hte = 1'b1;
  logic mwe = 1'b0;
  logic iwe = 1'b0;
  logic iwd = 1'b0;
  logic deleg = 1'b0;
  logic load = 1'b0;
  logic mie = 1'b0;
  logic sie = 1'b0;
  logic env = 1'b0;
  logic swe = 1'b0;
  logic henv = 1'b1;
  logic [11:0] addr = CSR_CMP;
  logic [63:0] wdata = 64'h0;
  logic [63:0] menv = 64'h8000000000000000;
  logic [63:0] load_val = 64'h0;
  priv_t priv = MODE_M;
  logic [63:0] time_w, rdata;
  logic hit, ill, vtrap, pend, ena, irqm, irqs;
  int err_count = 0;
  int samples_checked = 0;

  time_source plat (.ref_clk_i(clk), .srst_i(srst), .load_i(load), .load_val_i(load_val),
    .time_o(time_w));
  // every input is driven, so no rule hides behind a tied pin
  supervisor_timer_compare #(.XLEN(64), .IMPLEMENTED(1'b1)) dut (
    .ref_clk_i(clk), .srst_i(srst), .time_i(time_w), .csr_en_i(en), .csr_we_i(we),
    .csr_addr_i(addr), .csr_wdata_i(wdata), .priv_i(priv), .virt_i(virt), .menv_cfg_i(menv),
    .time_access_enable_i(tae), .hyp_time_access_enable_i(hte), .henv_facility_enable_i(henv),
    .mip_supervisor_timer_pending_we_i(mwe), .mip_supervisor_timer_pending_wdata_i(iwd), .env_supervisor_timer_pending_i(env), .mie_supervisor_timer_enable_we_i(iwe),
    .sie_supervisor_timer_enable_we_i(swe), .supervisor_timer_enable_wdata_i(iwd), .sti_delegated_i(deleg), .mstatus_mie_i(mie),
    .mstatus_sie_i(sie), .csr_rdata_o(rdata), .csr_hit_o(hit), .illegal_o(ill),
    .virt_trap_o(vtrap), .supervisor_timer_pending_o(pend), .supervisor_timer_enable_o(ena),
    .irq_m_o(irqm), .irq_s_o(irqs));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one-cycle access strobe; answer is registered at the taking edge, looked at just after it
  task automatic acc(input logic w, input logic [11:0] a, input logic [63:0] d, input priv_t p);
    @(posedge clk);
    en <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
    priv <= p;
    @(posedge clk);
    en <= 1'b0;
    #1;
  endtask

  // pulse either the machine pending write or the enable write
  task automatic strobe(input logic m, input logic v);
    @(posedge clk);
    mwe <= m;
    iwe <= ~m;
    iwd <= v;
    @(posedge clk);
    mwe <= 1'b0;
    iwe <= 1'b0;
    step(3);
  endtask

  // pending may lag the compare, so poll under a bound
  task automatic wait_pend(input logic exp);
    int n;
    n = 0;
    while (pend !== exp && n < 10) begin
      step(1);
      n++;
    end
    chk({63'h0, pend}, {63'h0, exp});
    if (pend !== exp) summarize();
  endtask

  initial begin
    step(3);
    @(posedge clk);
    srst <= 1'b0;
    step(1);
    chk({57'h0, pend, ena, irqm, irqs, hit, ill, vtrap}, 64'h0);
    chk(rdata, 64'h0);
    acc(1'b0, CSR_CMP, 64'h0, MODE_M);
    chk({63'h0, hit}, 64'h1);
    chk(rdata, CMP_RESET);
    $display("test reset done");
    @(posedge clk);
    load <= 1'b1;
    load_val <= 64'h8000000000000000;
    @(posedge clk);
    load <= 1'b0;
    acc(1'b1, CSR_CMP, 64'h7FFFFFFFFFFFFFFF, MODE_M);
    wait_pend(1'b1);
    acc(1'b0, CSR_CMP, 64'h0, MODE_M);
    chk(rdata, 64'h7FFFFFFFFFFFFFFF);
    acc(1'b1, CSR_CMP, 64'hFFFF000000000000, MODE_S);
    chk({63'h0, hit}, 64'h1);
    wait_pend(1'b0);
    strobe(1'b1, 1'b1);
    chk({63'h0, pend}, 64'h0);
    $display("test compare done");
    @(posedge clk);
    tae <= 1'b0;
    acc(1'b1, CSR_CMP, 64'h0, MODE_S);
    chk({62'h0, hit, ill}, 64'h1);
    @(posedge clk);
    tae <= 1'b1;
    menv <= 64'h0;
    acc(1'b1, CSR_CMP, 64'h0, MODE_S);
    chk({62'h0, hit, ill}, 64'h1);
    strobe(1'b1, 1'b1);
    chk({63'h0, pend}, 64'h1);
    strobe(1'b1, 1'b0);
    chk({63'h0, pend}, 64'h0);
    @(posedge clk);
    env <= 1'b1;
    step(3);
    chk({63'h0, pend}, 64'h1);
    @(posedge clk);
    env <= 1'b0;
    menv <= 64'h8000000000000000;
    virt <= 1'b1;
    hte <= 1'b0;
    acc(1'b1, CSR_CMP, 64'h0, MODE_S);
    chk({62'h0, ill, vtrap}, 64'h1);
    @(posedge clk);
    hte <= 1'b1;
    henv <= 1'b0;
    acc(1'b1, CSR_CMP, 64'h0, MODE_S);
    chk({62'h0, ill, vtrap}, 64'h1);
    @(posedge clk);
    henv <= 1'b1;
    acc(1'b1, CSR_CMP, 64'hFFFF000000000000, MODE_S);
    chk({61'h0, hit, ill, vtrap}, 64'h4);
    acc(1'b1, CSR_CMP, 64'h0, MODE_U);
    chk({62'h0, ill, vtrap}, 64'h1);
    @(posedge clk);
    virt <= 1'b0;
    acc(1'b1, CSR_CMP, 64'h0, MODE_U);
    chk({62'h0, hit, ill}, 64'h1);
    acc(1'b0, CSR_CMP, 64'h0, MODE_M);
    chk(rdata, 64'hFFFF000000000000);
    acc(1'b1, CSR_CMP_HI, 64'h0, MODE_M);
    chk({61'h0, hit, ill, vtrap}, 64'h0);
    $display("test gating done");
    acc(1'b1, CSR_CMP, 64'h0, MODE_M);
    wait_pend(1'b1);
    strobe(1'b0, 1'b1);
    chk({63'h0, ena}, 64'h1);
    @(posedge clk);
    mie <= 1'b1;
    step(3);
    chk({62'h0, irqm, irqs}, 64'h2);
    @(posedge clk);
    mie <= 1'b0;
    step(3);
    chk({62'h0, irqm, irqs}, 64'h0);
    @(posedge clk);
    priv <= MODE_S;
    step(3);
    chk({62'h0, irqm, irqs}, 64'h2);
    @(posedge clk);
    deleg <= 1'b1;
    step(3);
    chk({62'h0, irqm, irqs}, 64'h0);
    @(posedge clk);
    sie <= 1'b1;
    step(3);
    chk({62'h0, irqm, irqs}, 64'h1);
    @(posedge clk);
    sie <= 1'b0;
    priv <= MODE_U;
    step(3);
    chk({62'h0, irqm, irqs}, 64'h1);
    @(posedge clk);
    swe <= 1'b1;
    iwd <= 1'b0;
    @(posedge clk);
    swe <= 1'b0;
    step(3);
    chk({62'h0, ena, irqs}, 64'h0);
    $display("test interrupt done");
    // reset in mid-run with pending high must bring everything back to its quiet state
    @(posedge clk);
    srst <= 1'b1;
    step(3);
    @(posedge clk);
    srst <= 1'b0;
    step(1);
    chk({57'h0, pend, ena, irqm, irqs, hit, ill, vtrap}, 64'h0);
    acc(1'b0, CSR_CMP, 64'h0, MODE_M);
    chk(rdata, CMP_RESET);
    $display("test reset again done");
    summarize();
  end
endmodule
